// [logic/istc_top.v]
// Fill-start, tx-start, signal-strength and lock status/control block
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "istc_defines.vh"
module istc_top #(
   parameter CW = 7
) (
   input  wire          mclk,
   input  wire          rst,
   input  wire [7:0]    addr,
   input  wire [7:0]    wdata,
   input  wire          wr,
   input  wire          rd,
   output reg  [7:0]    rdata,
   input  wire          sync_det,
   input  wire          fifo_full,
   input  wire          fifo_empty,
   input  wire [CW-1:0] fifo_count,
   input  wire          fifo_overrun,
   input  wire          tx_last_bit,
   input  wire [7:0]    strength_val,
   input  wire          pll_lock,
   output reg           fill_en,
   output reg           fifo_flush,
   output reg           tx_start,
   output reg           irq0,
   output reg           lock_pin_o,
   output reg           lock_pin_oe,
   output reg           irq
);
   ////////////////////////////////////////////////////////////////////////
   // Sync, lock, last-bit and overrun pin inputs pass two flops before use
   wire       sync_s;
   wire       lock_s;
   wire       last_s;
   wire       ovr_s;
   istc_sync2 #(.W(4)) u_sync (
      .mclk (mclk),
      .rst  (rst),
      .d    ({sync_det, pll_lock, tx_last_bit, fifo_overrun}),
      .q    ({sync_s, lock_s, last_s, ovr_s})
   );
   ////////////////////////////////////////////////////////////////////////
   // Registers
   reg        fill_sel_r;
   reg        fill_ctl_r;
   reg        tx_done_r;
   reg        tx_sel_r;
   reg        str_en_r;
   reg        str_flag_r;
   reg        lock_flag_r;
   reg        lock_pin_en_r;
   reg [7:0]  level_r;
   reg [1:0]  mode_r;
   reg [7:0]  mask_r;
   reg [7:0]  fillset_r;
   reg        ovr_flag_r;
   reg        sync_d_r;
   reg        lock_d_r;
   reg        last_d_r;
   reg        ovr_d_r;
   reg        above_d_r;
   wire       wr_ctrl = wr && (addr == `ISTC_ADDR_CTRL);
   wire       buffered = (mode_r == `ISTC_MODE_BUF);
   wire       packet = mode_r[1];
   wire       above = (strength_val > level_r);
   wire       sync_rise = sync_s && !sync_d_r;
   wire       lock_rise = lock_s && !lock_d_r;
   wire       last_rise = last_s && !last_d_r;
   wire       ovr_rise = ovr_s && !ovr_d_r;
   // Event on the flag's own rise, so enabling while above still reports it
   wire       above_rise = above && str_en_r && !above_d_r;
   wire [4:0] ev_q;
   wire [4:0] ev_clr;
   // Events for the interrupt status bank
   wire [4:0] ev_set = {sync_rise, ovr_rise, lock_rise, above_rise, last_rise};
   assign ev_clr = (rd && (addr == `ISTC_ADDR_IRQ_STAT)) ? 5'h1f : 5'h00;
   istc_sticky #(.N(5)) u_irq (
      .mclk (mclk),
      .rst  (rst),
      .set  (ev_set),
      .clr  (ev_clr),
      .q    (ev_q)
   );
   // Edge detect history
   always @(posedge mclk) begin
      if (rst) begin
         sync_d_r  <= 1'b0;
         lock_d_r  <= 1'b0;
         last_d_r  <= 1'b0;
         ovr_d_r   <= 1'b0;
         above_d_r <= 1'b0;
      end else begin
         sync_d_r  <= sync_s;
         lock_d_r  <= lock_s;
         last_d_r  <= last_s;
         ovr_d_r   <= ovr_s;
         above_d_r <= above && str_en_r;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Plain configuration registers
   always @(posedge mclk) begin
      if (rst) begin
         fill_sel_r    <= 1'b0;
         tx_sel_r      <= 1'b0;
         str_en_r      <= 1'b0;
         lock_pin_en_r <= 1'b1;
         level_r       <= `ISTC_LEVEL_RESET;
         mode_r        <= `ISTC_MODE_RESET;
         mask_r        <= `ISTC_MASK_RESET;
         fillset_r     <= `ISTC_FILLSET_RESET;
      end else if (wr) begin
         case (addr)
            `ISTC_ADDR_CTRL: begin
               fill_sel_r    <= wdata[`ISTC_BIT_FILL_SEL];
               tx_sel_r      <= wdata[`ISTC_BIT_TX_SEL];
               str_en_r      <= wdata[`ISTC_BIT_STR_EN];
               lock_pin_en_r <= wdata[`ISTC_BIT_LOCK_PIN];
            end
            `ISTC_ADDR_LEVEL:   level_r   <= wdata;
            `ISTC_ADDR_MODE:    mode_r    <= wdata[1:0];
            `ISTC_ADDR_IRQ_MASK: mask_r   <= wdata;
            `ISTC_ADDR_FILLSET: fillset_r <= wdata;
            default: ;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Fill control: auto on sync or manual
   always @(posedge mclk) begin
      if (rst) begin
         fill_ctl_r <= 1'b0;
      end else if (wr_ctrl && wdata[`ISTC_BIT_FILL_SEL]) begin
         // manual start and stop, also on the write that selects manual
         fill_ctl_r <= wdata[`ISTC_BIT_FILL_CTL];
      end else if (fill_sel_r) begin
         // Leaving manual mode keeps the bit until the next rearm
         fill_ctl_r <= fill_ctl_r;
      end else if (sync_rise && buffered) begin
         fill_ctl_r <= 1'b1;
      end else if (wr_ctrl && wdata[`ISTC_BIT_FILL_CTL] && !ovr_flag_r) begin
         fill_ctl_r <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Hardware-set flags; sets beat clears
   always @(posedge mclk) begin
      if (rst) begin
         tx_done_r   <= 1'b0;
         str_flag_r  <= 1'b0;
         lock_flag_r <= 1'b0;
         ovr_flag_r  <= 1'b0;
      end else begin
         // done on last bit out, cleared when tx restarts
         if (last_rise) begin
            tx_done_r <= 1'b1;
         end else if (tx_start && !fifo_empty) begin
            tx_done_r <= 1'b0;
         end
         // set above level, stays until 1 written
         if (above && str_en_r) begin
            str_flag_r <= 1'b1;
         end else if (wr_ctrl && wdata[`ISTC_BIT_STR_FLAG]) begin
            str_flag_r <= 1'b0;
         end
         // lock flag, sticky until 1 written
         if (lock_rise) begin
            lock_flag_r <= 1'b1;
         end else if (wr_ctrl && wdata[`ISTC_BIT_LOCK_FLAG]) begin
            lock_flag_r <= 1'b0;
         end
         if (ovr_rise) begin
            ovr_flag_r <= 1'b1;
         end else if (wr && (addr == `ISTC_ADDR_OVR) && wdata[0]) begin
            ovr_flag_r <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Tx start condition and irq0 source
   reg tx_go;
   reg irq0_nxt;
   always @* begin
      tx_go    = 1'b0;
      irq0_nxt = 1'b0;
      if (tx_sel_r && (buffered || packet)) begin
         tx_go    = !fifo_empty;
         irq0_nxt = !fifo_empty;
      end else if (buffered) begin
         tx_go    = fifo_full;
         irq0_nxt = !fifo_empty;
      end else if (packet) begin
         tx_go    = ({1'b0, fifo_count} >= {1'b0, fillset_r[CW-1:0]});
         irq0_nxt = tx_go;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always @(posedge mclk) begin
      if (rst) begin
         fill_en     <= 1'b0;
         fifo_flush  <= 1'b0;
         tx_start    <= 1'b0;
         irq0        <= 1'b0;
         lock_pin_o  <= 1'b0;
         lock_pin_oe <= 1'b0;
         irq         <= 1'b0;
      end else begin
         // fill only applies in buffered mode
         fill_en     <= fill_ctl_r && buffered && !ovr_flag_r;
         fifo_flush  <= wr && (addr == `ISTC_ADDR_OVR) && wdata[0];
         tx_start    <= tx_go;
         irq0        <= irq0_nxt;
         // drive lock state only when enabled
         lock_pin_o  <= lock_s;
         lock_pin_oe <= lock_pin_en_r;
         irq         <= |(ev_q & mask_r[4:0]);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe
   reg [7:0] rd_nxt;
   always @* begin
      rd_nxt = 8'h00;
      case (addr)
         // fill bit reads back live state
         `ISTC_ADDR_CTRL:     rd_nxt = {fill_sel_r, fill_ctl_r, tx_done_r, tx_sel_r,
                                       str_en_r, str_flag_r, lock_flag_r, lock_pin_en_r};
         `ISTC_ADDR_LEVEL:    rd_nxt = level_r;
         `ISTC_ADDR_MODE:     rd_nxt = {6'h00, mode_r};
         `ISTC_ADDR_IRQ_STAT: rd_nxt = {3'h0, ev_q};
         `ISTC_ADDR_IRQ_MASK: rd_nxt = mask_r;
         `ISTC_ADDR_OVR:      rd_nxt = {7'h00, ovr_flag_r};
         `ISTC_ADDR_FILLSET:  rd_nxt = fillset_r;
         `ISTC_ADDR_STRENGTH: rd_nxt = strength_val;
         default:             rd_nxt = 8'h00;
      endcase
   end
   always @(posedge mclk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         rdata <= rd_nxt;
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule // istc_top
`default_nettype wire

// [logic/istc_defines.vh]
// Register map, field positions and reset values of the fill/tx/irq status block
`ifndef ISTC_DEFINES_VH
`define ISTC_DEFINES_VH
`define ISTC_ADDR_CTRL      8'h0e
`define ISTC_ADDR_LEVEL     8'h0f
`define ISTC_ADDR_MODE      8'h10
`define ISTC_ADDR_IRQ_STAT  8'h11
`define ISTC_ADDR_IRQ_MASK  8'h12
`define ISTC_ADDR_OVR       8'h13
`define ISTC_ADDR_FILLSET   8'h14
`define ISTC_ADDR_STRENGTH  8'h15
`define ISTC_BIT_FILL_SEL   7
`define ISTC_BIT_FILL_CTL   6
`define ISTC_BIT_TX_DONE    5
`define ISTC_BIT_TX_SEL     4
`define ISTC_BIT_STR_EN     3
`define ISTC_BIT_STR_FLAG   2
`define ISTC_BIT_LOCK_FLAG  1
`define ISTC_BIT_LOCK_PIN   0
`define ISTC_CTRL_RESET     8'h01
`define ISTC_LEVEL_RESET    8'h00
`define ISTC_MODE_RESET     2'h0
`define ISTC_MODE_CONT      2'h0
`define ISTC_MODE_BUF       2'h1
`define ISTC_MASK_RESET     8'h00
`define ISTC_FILLSET_RESET  8'h20
`define ISTC_EV_TX_DONE     0
`define ISTC_EV_STRENGTH    1
`define ISTC_EV_LOCK        2
`define ISTC_EV_OVERRUN     3
`define ISTC_EV_SYNC        4
`endif

// [logic/istc_sync2.v]
// Two-flop synchroniser, one per bit
`timescale 1ns/10ps
`default_nettype none
module istc_sync2 #(
   parameter W = 1
) (
   input  wire         mclk,
   input  wire         rst,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   // First stage feeds only the second stage
   always @(posedge mclk) begin
      if (rst) begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule // istc_sync2
`default_nettype wire

// [logic/istc_sticky.v]
// Bank of sticky event bits, set wins over clear
`timescale 1ns/10ps
`default_nettype none
module istc_sticky #(
   parameter N = 5
) (
   input  wire         mclk,
   input  wire         rst,
   input  wire [N-1:0] set,
   input  wire [N-1:0] clr,
   output wire [N-1:0] q
);
   reg [N-1:0] q_r;
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_bit
         // A set arriving with a clear survives
         always @(posedge mclk) begin
            if (rst) begin
               q_r[i] <= 1'b0;
            end else if (set[i]) begin
               q_r[i] <= 1'b1;
            end else if (clr[i]) begin
               q_r[i] <= 1'b0;
            end
         end
      end
   endgenerate
   assign q = q_r;
endmodule // istc_sticky
`default_nettype wire

// [bench/istc_assertions.sv]
// Port checker for the fill/tx/interrupt status block
`timescale 1ns/10ps
`default_nettype none
`include "istc_defines.vh"
module istc_assertions #(
   parameter CW = 7
) (
   input wire          mclk,
   input wire          rst,
   input wire [7:0]    addr,
   input wire [7:0]    wdata,
   input wire          wr,
   input wire          rd,
   input wire [7:0]    rdata,
   input wire          fifo_full,
   input wire          fifo_empty,
   input wire [CW-1:0] fifo_count,
   input wire          fifo_flush,
   input wire          tx_start,
   input wire          irq0,
   input wire          lock_pin_oe
);
   reg [7:0] ctl_r;
   reg [7:0] lvl_r;
   reg [7:0] fil_r;
   reg [1:0] mod_r;
   ////////////////////////////////////////////////////////////////
   // Shadow of the control, level, fill-set and mode settings, snooped from the register port
   always @(posedge mclk) begin
      if (rst) begin
         ctl_r <= 8'h01;
         lvl_r <= 8'h00;
         fil_r <= 8'h20;
         mod_r <= 2'h0;
      end else if (wr) begin
         if (addr == 8'h0e) ctl_r <= wdata;
         if (addr == 8'h0f) lvl_r <= wdata;
         if (addr == 8'h14) fil_r <= wdata;
         if (addr == 8'h10) mod_r <= wdata[1:0];
      end
   end
   // Start condition and first pin source; continuous mode left open
   wire ne   = !fifo_empty;
   wire thr  = ({1'b0, fifo_count} >= fil_r);
   wire sel  = ctl_r[4];
   wire go_c = (mod_r == 2'h1) ? (sel ? ne : fifo_full) : (sel ? ne : thr);
   wire i0_c = (mod_r[1] && !sel) ? thr : ne;
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_flush_wr;
      wr && addr == 8'h13 && wdata[0];
   endsequence
   a_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data not idle");
   a_unmapped_zero: assert property (rd && (addr < 8'h0e || addr > 8'h15) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_level_read: assert property (rd && addr == 8'h0f |=> rdata == $past(lvl_r))
      else $error("level readback wrong");
   a_lock_pin_en: assert property (!$past(rst) |-> lock_pin_oe == $past(ctl_r[0]))
      else $error("lock pin enable wrong");
   a_flush_pulse: assert property (s_flush_wr |=> fifo_flush ##1 !fifo_flush)
      else $error("flush pulse missing");
   a_flush_cause: assert property (fifo_flush |-> $past(wr && addr == 8'h13 && wdata[0]))
      else $error("flush without cause");
   a_tx_start: assert property ($past(mod_r) != 2'h0 |-> tx_start == $past(go_c))
      else $error("tx start wrong");
   a_irq0_src: assert property ($past(mod_r) != 2'h0 |-> irq0 == $past(i0_c))
      else $error("irq0 source wrong");
endmodule // istc_assertions
bind istc_top istc_assertions #(.CW(CW)) u_chk (.mclk(mclk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fifo_full(fifo_full),
   .fifo_empty(fifo_empty), .fifo_count(fifo_count), .fifo_flush(fifo_flush),
   .tx_start(tx_start), .irq0(irq0), .lock_pin_oe(lock_pin_oe));
`default_nettype wire

// [bench/istc_far.sv]
// FIFO side model: byte count, full and empty flags
`timescale 1ns/10ps
`default_nettype none
module istc_far (
   input  wire       mclk,
   input  wire [6:0] want,
   input  wire       fifo_flush,
   output logic [6:0] fifo_count,
   output wire       fifo_full,
   output wire       fifo_empty
);
   initial fifo_count = 7'h00;
   // flush empties FIFO
   // One byte per clock, so threshold crossings are seen one step at a time
   always @(posedge mclk) begin
      if (fifo_flush) fifo_count <= 7'h00;
      else if (fifo_count < want) fifo_count <= fifo_count + 7'h01;
      else if (fifo_count > want) fifo_count <= fifo_count - 7'h01;
   end
   assign fifo_full  = (fifo_count == 7'h40);
   assign fifo_empty = (fifo_count == 7'h00);
endmodule // istc_far
`default_nettype wire

// [bench/tb_irq_status_fifo_tx_control.sv]
// Register-level testbench of the status/control block
`timescale 1ns/10ps
`default_nettype none
module tb_irq_status_fifo_tx_control;
   logic mclk = 0, rst = 1, wr = 0, rd = 0, sync_det = 0, tx_last_bit = 0;
   logic pll_lock = 0, fifo_overrun = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, strength_val = 8'h00;
   logic [6:0] want = 7'h00;
   wire [7:0] rdata;
   wire [6:0] fifo_count;
   wire fifo_full, fifo_empty, fill_en, fifo_flush, tx_start, irq0, lk_o, lk_oe, irq;
   integer err_count = 0, total_checks = 0;
   ////////////////////////////////////////////////////////////////
   istc_top #(.CW(7)) uut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .sync_det(sync_det), .fifo_full(fifo_full),
      .fifo_empty(fifo_empty), .fifo_count(fifo_count), .fifo_overrun(fifo_overrun),
      .tx_last_bit(tx_last_bit), .strength_val(strength_val), .pll_lock(pll_lock),
      .fill_en(fill_en), .fifo_flush(fifo_flush), .tx_start(tx_start), .irq0(irq0),
      .lock_pin_o(lk_o), .lock_pin_oe(lk_oe), .irq(irq));
   istc_far u_far (.mclk(mclk), .want(want), .fifo_flush(fifo_flush),
      .fifo_count(fifo_count), .fifo_full(fifo_full), .fifo_empty(fifo_empty));
   // 10 MHz clock
   always #50 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   // Read data is looked at only in the cycle after the strobe
   task rd8(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // Program mode and control, let the FIFO settle, check start and pin
   task txc(input logic [1:0] m, input logic [7:0] c, input logic [6:0] w, input logic [1:0] e);
      wr8(8'h10, {6'h00, m});
      wr8(8'h0e, c);
      want <= w;
      tick(70);
      chk({6'h00, tx_start, irq0}, {6'h00, e});
   endtask
   task test_done;
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Watchdog sized well above the expected run
   initial begin
      #(3000 * 100);
      err_count = err_count + 1;
      test_done;
   end
   initial begin
      tick(4);
      rst <= 1'b0;
      rd8(8'h0e, 8'h01);
      rd8(8'h0f, 8'h00);
      wr8(8'h20, 8'hff);
      rd8(8'h20, 8'h00);
      wr8(8'h0f, 8'ha5);
      rd8(8'h0f, 8'ha5);
      // Strength source gated, then enabled, sticky, then cleared
      wr8(8'h0f, 8'h40);
      strength_val <= 8'h80;
      tick(3);
      rd8(8'h0e, 8'h01);
      wr8(8'h0e, 8'h09);
      tick(3);
      rd8(8'h0e, 8'h0d);
      strength_val <= 8'h10;
      tick(3);
      wr8(8'h0e, 8'h09);
      rd8(8'h0e, 8'h0d);
      wr8(8'h0e, 8'h0d);
      tick(2);
      rd8(8'h0e, 8'h09);
      // Lock flag, masked interrupt, read-to-clear status, lock pin
      rd8(8'h11, 8'h02);
      wr8(8'h12, 8'h04);
      pll_lock <= 1'b1;
      tick(6);
      chk({7'h00, irq}, 8'h01);
      rd8(8'h0e, 8'h0b);
      rd8(8'h11, 8'h04);
      tick(1);
      chk({7'h00, irq}, 8'h00);
      chk({7'h00, lk_oe}, 8'h01);
      chk({7'h00, lk_o}, 8'h01);
      wr8(8'h0e, 8'h0a);
      tick(1);
      chk({7'h00, lk_oe}, 8'h00);
      rd8(8'h0e, 8'h08);
      // Last bit out of the shifter
      tx_last_bit <= 1'b1;
      tick(1);
      tx_last_bit <= 1'b0;
      tick(5);
      rd8(8'h0e, 8'h28);
      // Start conditions over buffered and packet data modes
      wr8(8'h14, 8'h05);
      txc(2'h1, 8'h08, 7'h0a, 2'h1);
      txc(2'h1, 8'h08, 7'h40, 2'h3);
      txc(2'h1, 8'h18, 7'h01, 2'h3);
      txc(2'h2, 8'h18, 7'h01, 2'h3);
      txc(2'h3, 8'h08, 7'h04, 2'h0);
      txc(2'h3, 8'h08, 7'h05, 2'h3);
      want <= 7'h00;
      tick(10);
      // Automatic fill on sync, rearm, then manual control
      wr8(8'h10, 8'h01);
      wr8(8'h0e, 8'h08);
      sync_det <= 1'b1;
      tick(1);
      sync_det <= 1'b0;
      tick(5);
      chk({7'h00, fill_en}, 8'h01);
      rd8(8'h0e, 8'h48);
      wr8(8'h0e, 8'h48);
      tick(2);
      rd8(8'h0e, 8'h08);
      chk({7'h00, fill_en}, 8'h00);
      wr8(8'h0e, 8'hc8);
      tick(1);
      chk({7'h00, fill_en}, 8'h01);
      wr8(8'h0e, 8'h88);
      tick(1);
      chk({7'h00, fill_en}, 8'h00);
      // Overrun flag and its clearing flush
      fifo_overrun <= 1'b1;
      tick(1);
      fifo_overrun <= 1'b0;
      tick(5);
      rd8(8'h13, 8'h01);
      wr8(8'h13, 8'h01);
      tick(1);
      rd8(8'h13, 8'h00);
      test_done;
   end
endmodule // tb_irq_status_fifo_tx_control
`default_nettype wire
